// ---- iie_extender.sv ----
/*
 * I/O interrupt extender top: sixteen sublevels in two groups of eight
 * (data and service), APB register slave and a level interrupt output.
 * Assumes APB master on core_clk; inputs synchronous to core_clk.
 */
// Implementation choices: the register offsets and register access over APB.
// Behaviour
// - Split data and service into eight sublevels each
// - One shared identifier and priority for all
// - Per-sublevel program enable, sixteen of them
// - Program clears each pending request individually
// - Any group input going true requests
// - Host status input returns pending sublevels
`timescale 1ns/1ps
module iie_extender #(
    parameter int                 GROUP_LINES = iie_pkg::GROUP_LINES,
    parameter logic [7:0]         ORIGIN_ID   = iie_pkg::ORIGIN_ID_DEF, // Arbitrary value
    parameter logic [3:0]         PRIORITY    = iie_pkg::PRIORITY_DEF   // Arbitrary value
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [iie_pkg::ADDR_W-1:0] paddr,
    input  wire logic [iie_pkg::DATA_W-1:0] pwdata,
    output logic      [iie_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [GROUP_LINES-1:0]     dataLines,
    input  wire logic [GROUP_LINES-1:0]     serviceLines,
    output logic                            dataIrq,
    output logic                            serviceIrq,
    output logic [7:0]                      shared_origin_identifier,
    output logic [3:0]                      groupPriority,
    output logic                            irq
);
    localparam int N = 2 * GROUP_LINES;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b01,
        APB_ACCESS = 2'b10
    } iie_apb_t;

    iie_latch_if #(.N(N)) lb ();

    iie_apb_t                    apbState;
    iie_apb_t                    next_apbState;
    logic [N-1:0]                enable;
    logic [N-1:0]                next_enable;
    logic [iie_pkg::IST_W-1:0]   istat;
    logic [iie_pkg::IST_W-1:0]   next_istat;
    logic [iie_pkg::IST_W-1:0]   imask;
    logic [iie_pkg::IST_W-1:0]   next_imask;
    logic [iie_pkg::DATA_W-1:0]  rdata;
    logic [iie_pkg::DATA_W-1:0]  next_rdata;
    logic                        err;
    logic                        next_err;
    logic [N-1:0]                clearMask;
    logic [N-1:0]                active;
    logic [iie_pkg::IST_W-1:0]   groupReq;
    logic [iie_pkg::IST_W-1:0]   prevReq;
    logic [iie_pkg::IST_W-1:0]   next_prevReq;
    logic                        wrDone;
    logic                        rdDone;

    // Sixteen lines: data group low, service group high
    assign lb.lineIn    = {serviceLines, dataLines};
    assign lb.enable    = enable;
    assign lb.clearMask = clearMask;

    iie_latch_bank #(.N(N)) u_bank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .lb       (lb)
    );

    // Pending kept even when disabled; only the request is gated
    assign active = lb.pending & enable;
    assign groupReq[iie_pkg::IST_DATA] = |active[iie_pkg::DATA_LSB +: GROUP_LINES];
    assign groupReq[iie_pkg::IST_SERV] = |active[iie_pkg::SERV_LSB +: GROUP_LINES];

    // Constant identity shared by every sublevel
    assign shared_origin_identifier = ORIGIN_ID;
    assign groupPriority            = PRIORITY;

    // APB handshake: one wait-free access phase
    assign pready  = (apbState == APB_ACCESS);
    assign prdata  = rdata;
    assign pslverr = err & pready;
    assign wrDone  = psel & penable & pwrite & pready;
    assign rdDone  = psel & penable & !pwrite & pready;

    // Write-one-to-clear of pending requests
    always_comb begin
        clearMask = '0;
        if (wrDone && paddr == iie_pkg::OFF_RESET) begin
            clearMask = pwdata[N-1:0];
        end
    end

    // Bus state, control registers and read data
    always_comb begin
        next_apbState = apbState;
        next_enable   = enable;
        next_imask    = imask;
        next_rdata    = rdata;
        next_err      = err;
        case (apbState)
            APB_IDLE: begin
                if (psel && !penable) begin
                    next_apbState = APB_ACCESS;
                    next_err      = 1'b0;
                    next_rdata    = '0;
                    case (paddr)
                        iie_pkg::OFF_PENDING:
                            next_rdata[N-1:0] = lb.pending;
                        iie_pkg::OFF_ENABLE:
                            next_rdata[N-1:0] = enable;
                        iie_pkg::OFF_RESET: next_rdata = '0;
                        iie_pkg::OFF_ISTAT:
                            next_rdata[iie_pkg::IST_W-1:0] = istat;
                        iie_pkg::OFF_IMASK:
                            next_rdata[iie_pkg::IST_W-1:0] = imask;
                        iie_pkg::OFF_IDENT:
                            next_rdata[11:0] = {PRIORITY, ORIGIN_ID};
                        iie_pkg::OFF_RAW:
                            next_rdata[N-1:0] = lb.lineIn;
                        default: next_err = 1'b1;
                    endcase
                end
            end
            APB_ACCESS: begin
                next_apbState = APB_IDLE;
                if (wrDone && paddr == iie_pkg::OFF_ENABLE) begin
                    next_enable = pwdata[N-1:0];
                end
                if (wrDone && paddr == iie_pkg::OFF_IMASK) begin
                    next_imask = pwdata[iie_pkg::IST_W-1:0];
                end
            end
            default: next_apbState = APB_IDLE;
        endcase
    end

    // Sticky group events; read clears, new event wins
    always_comb begin
        next_prevReq = groupReq;
        next_istat   = istat;
        if (rdDone && paddr == iie_pkg::OFF_ISTAT) begin
            next_istat = '0;
        end
        next_istat = next_istat | (groupReq & ~prevReq);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            apbState <= APB_IDLE;
            enable   <= iie_pkg::ENABLE_RST;
            imask    <= iie_pkg::IMASK_RST;
            rdata    <= '0;
            err      <= 1'b0;
            istat    <= '0;
            prevReq  <= '0;
        end else begin
            apbState <= next_apbState;
            enable   <= next_enable;
            imask    <= next_imask;
            rdata    <= next_rdata;
            err      <= next_err;
            istat    <= next_istat;
            prevReq  <= next_prevReq;
        end
    end

    // Party-line requests follow enabled pending lines
    assign dataIrq    = groupReq[iie_pkg::IST_DATA];
    assign serviceIrq = groupReq[iie_pkg::IST_SERV];
    assign irq        = |(istat & imask);

    a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (enable[7:0] == 8'h00) |-> !dataIrq)
        else $error("disabled data group requested");
    a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrDone && paddr == iie_pkg::OFF_ENABLE) |=> (enable == $past(pwdata[N-1:0])))
        else $error("enable not written");
    a_pending_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == iie_pkg::OFF_PENDING && apbState == APB_IDLE)
        |=> (prdata[N-1:0] == $past(lb.pending) && pready))
        else $error("pending read wrong");
    a_clear_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrDone && paddr == iie_pkg::OFF_RESET && pwdata[8] && !serviceLines[0])
        ##1 !serviceLines[0] |=> !lb.pending[8])
        else $error("service request not cleared");
    a_edge_request: assert property (@(posedge core_clk) disable iff (!rst_n)
        (serviceLines[2] && !$past(serviceLines[2]) && enable[10]) |-> ##1 serviceIrq)
        else $error("service input did not request");
    a_data_line_map: assert property (@(posedge core_clk) disable iff (!rst_n)
        lb.lineIn[iie_pkg::DATA_LSB +: GROUP_LINES] == dataLines
        && lb.lineIn[iie_pkg::SERV_LSB +: GROUP_LINES] == serviceLines)
        else $error("data group mapping wrong");
    a_ident_const: assert property (@(posedge core_clk) disable iff (!rst_n)
        shared_origin_identifier == ORIGIN_ID && groupPriority == PRIORITY)
        else $error("identity changed");
    a_pending_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (lb.pending[1] && clearMask[1] == 1'b0) |=> lb.pending[1])
        else $error("request lost without clear");
endmodule

// ---- iie_pkg.sv ----
/*
 * Package for the I/O interrupt extender: register map, field layout,
 * reset values and sizes shared by the design files.
 * Assumes an APB master with 32-bit data and word-aligned registers.
 */
package iie_pkg;
    localparam int GROUP_LINES = 8;
    localparam int NUM_LINES   = 16;
    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PENDING = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_ENABLE  = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_RESET   = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_ISTAT   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_IMASK   = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_IDENT   = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_RAW     = 12'h018;

    // Field positions: data group low byte, service group next byte
    localparam int DATA_LSB = 0;
    localparam int SERV_LSB = 8;

    // Interrupt status bits
    localparam int IST_DATA = 0;
    localparam int IST_SERV = 1;
    localparam int IST_W    = 2;

    // Reset values
    localparam logic [NUM_LINES-1:0] ENABLE_RST = 16'h0000;
    localparam logic [IST_W-1:0]     IMASK_RST  = 2'h0;

    // Arbitrary neutral identity values
    localparam logic [7:0] ORIGIN_ID_DEF = 8'h5A;
    localparam logic [3:0] PRIORITY_DEF  = 4'h3;
endpackage

// ---- iie_latch_if.sv ----
/*
 * Interface between the extender top and its request latch bank.
 * Assumes one clock shared by both modules.
 */
`timescale 1ns/1ps
interface iie_latch_if #(parameter int N = 16);
    logic [N-1:0] lineIn;
    logic [N-1:0] enable;
    logic [N-1:0] clearMask;
    logic [N-1:0] pending;
    modport ctrl (output lineIn, output enable, output clearMask, input pending);
    modport bank (input lineIn, input enable, input clearMask, output pending);
endinterface

// ---- iie_latch_bank.sv ----
/*
 * Bank of sticky request latches, one per sublevel.
 * Assumes inputs synchronous to core_clk; a clear and a new rise in
 * the same cycle keep the request set.
 */
`timescale 1ns/1ps
module iie_latch_bank #(
    parameter int N = 16
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    iie_latch_if.bank   lb
);
    logic [N-1:0] prevIn;
    logic [N-1:0] next_prevIn;
    logic [N-1:0] latched;
    logic [N-1:0] next_latched;

    // Per sublevel: capture a going-true edge, hold until cleared
    for (genvar i = 0; i < N; i++) begin : g_line
        always_comb begin
            next_prevIn[i] = lb.lineIn[i];
            if (lb.lineIn[i] && !prevIn[i]) begin
                next_latched[i] = 1'b1;
            end else if (lb.clearMask[i]) begin
                next_latched[i] = 1'b0;
            end else begin
                next_latched[i] = latched[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prevIn  <= '0;
            latched <= '0;
        end else begin
            prevIn  <= next_prevIn;
            latched <= next_latched;
        end
    end

    assign lb.pending = latched;

    a_clear_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (lb.clearMask[0] && !(lb.lineIn[0] && !prevIn[0])) |=> !latched[0])
        else $error("cleared request still pending");
    a_edge_latches: assert property (@(posedge core_clk) disable iff (!rst_n)
        (lb.lineIn[3] && !prevIn[3]) |=> latched[3])
        else $error("rising input not held");
endmodule

// ---- iie_source_model.sv ----
/*
 * External signal sources standing on the far side of the extender.
 * Assumes the bench sets request levels just after a rising edge.
 */
`timescale 1ns/1ps
module iie_source_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] request,
    output logic      [7:0]  dataLines,
    output logic      [7:0]  serviceLines
);
    // Registered lines; held low in reset so no spurious rise at release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dataLines    <= 8'h00;
            serviceLines <= 8'h00;
        end else begin
            dataLines    <= request[7:0];
            serviceLines <= request[15:8];
        end
    end
endmodule

// ---- tb_io_interrupt_extender.sv ----
/*
 * Self-checking bench for the I/O interrupt extender.
 * Assumes the zero-wait APB slave and the source model beside it.
 */
`timescale 1ns/1ps
module tb_io_interrupt_extender;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  dataLines;
    logic [7:0]  serviceLines;
    logic        dataIrq;
    logic        serviceIrq;
    logic [7:0]  originId;
    logic [3:0]  groupPriority;
    logic        irq;
    logic [15:0] request  = 16'h0000;
    int          fails    = 0;
    int          check_count = 0;
    logic [31:0] rd;
    logic        er;

    always #10 core_clk = ~core_clk;

    iie_extender u_iie_extender (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dataLines(dataLines),
        .serviceLines(serviceLines), .dataIrq(dataIrq), .serviceIrq(serviceIrq),
        .shared_origin_identifier(originId), .groupPriority(groupPriority), .irq(irq));

    iie_source_model u_iie_source_model (.core_clk(core_clk), .rst_n(rst_n),
        .request(request), .dataLines(dataLines), .serviceLines(serviceLines));

    // Compare and count; mismatches print at once
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; pready, data and error taken at the completing rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Reset values, identity, unmapped refusal
    task automatic t_reset_ident();
        apb(1'b0, iie_pkg::OFF_PENDING, 32'h0); chk("pending", rd, 32'h0);
        apb(1'b0, iie_pkg::OFF_ENABLE, 32'h0);  chk("enable", rd, 32'h0);
        apb(1'b0, iie_pkg::OFF_IDENT, 32'h0);
        chk("ident", rd, {20'h0, iie_pkg::PRIORITY_DEF, iie_pkg::ORIGIN_ID_DEF});
        chk("originPort", {24'h0, originId}, {24'h0, iie_pkg::ORIGIN_ID_DEF});
        chk("prioPort", {28'h0, groupPriority}, {28'h0, iie_pkg::PRIORITY_DEF});
        apb(1'b0, 12'h0FC, 32'h0); chk("unmappedErr", {31'h0, er}, 32'h1);
        chk("unmappedData", rd, 32'h0);
    endtask

    // Each sublevel alone enabled; partner in the other group disabled
    task automatic t_sublevels();
        int j;
        for (int i = 0; i < 16; i++) begin
            j = i ^ 8;
            apb(1'b1, iie_pkg::OFF_ENABLE, 32'h1 << i);
            request <= 16'h0001 << i | 16'h0001 << j;
            wait_cyc(3);
            chk("dataIrq", {31'h0, dataIrq}, {31'h0, i < 8});
            chk("serviceIrq", {31'h0, serviceIrq}, {31'h0, i >= 8});
            apb(1'b0, iie_pkg::OFF_PENDING, 32'h0);
            chk("pendBoth", rd, (32'h1 << i) | (32'h1 << j));
            apb(1'b1, iie_pkg::OFF_RESET, 32'h1 << i);
            apb(1'b0, iie_pkg::OFF_PENDING, 32'h0);
            chk("pendCleared", rd, 32'h1 << j);
            chk("irqGone", {30'h0, dataIrq, serviceIrq}, 32'h0);
            apb(1'b1, iie_pkg::OFF_RESET, 32'h1 << j);
            request <= 16'h0000;
            apb(1'b0, iie_pkg::OFF_PENDING, 32'h0);
            chk("pendNone", rd, 32'h0);
        end
    endtask

    // Group status, masking and read-to-clear
    task automatic t_interrupt();
        apb(1'b0, iie_pkg::OFF_ISTAT, 32'h0); chk("istatBoth", rd, 32'h3);
        apb(1'b0, iie_pkg::OFF_ISTAT, 32'h0); chk("istatClr", rd, 32'h0);
        apb(1'b1, iie_pkg::OFF_IMASK, 32'h1);
        apb(1'b1, iie_pkg::OFF_ENABLE, 32'hFFFF);
        request <= 16'h0800;
        wait_cyc(4);
        chk("irqMasked", {31'h0, irq}, 32'h0);
        request <= 16'h0820;
        wait_cyc(4);
        chk("irqData", {31'h0, irq}, 32'h1);
        apb(1'b0, iie_pkg::OFF_RAW, 32'h0); chk("raw", rd, 32'h0820);
        apb(1'b0, iie_pkg::OFF_ISTAT, 32'h0); chk("istatRead", rd, 32'h3);
        wait_cyc(1);
        chk("irqDropped", {31'h0, irq}, 32'h0);
        request <= 16'h0000;
        apb(1'b1, iie_pkg::OFF_RESET, 32'hFFFF);
        apb(1'b0, iie_pkg::OFF_PENDING, 32'h0); chk("pendEnd", rd, 32'h0);
    endtask

    // Verdict and end of run
    task automatic complete_run();
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset_ident();
        t_sublevels();
        t_interrupt();
        complete_run();
    end
endmodule
